// ==== verilog/occ_clock_ctrl.sv ====
// Clock control register block: four registers on APB
// Assumes oscillators, PLL and failure monitor sit outside on pclk
//
// Notes on behaviour
// - Current source read-only, eight encodings
// - Writable new-source field, same encoding
// - Freeze bit blocks switches when monitor off
// - Pin-select guard blocks pin-select writes
// - PLL lock bit reflects the synchronised lock pin
// - Fail flag set by monitor, software clears
// - Secondary oscillator enable, resets off
// - Request bit starts switch, reads 0 after
// - Interrupt clears doze enable when recover set
// - Doze field divides by two to power
// - Doze enable clear forces 1:1 ratio
// - Fast RC postscaler 1..64, code 7 is 256
// - PLL postscale 2,4,reserved,8; resets 4
// - PLL prescale field plus two, resets 2
// - PLL multiplier field plus two, resets 50
// - Six-bit signed fast RC trim, resets zero
// - Unimplemented bits read 0, ignore writes
// - New source loads from configuration at reset
// - Same-source request cleared and aborted
// - Wait ten new-source cycles before changeover
// - Completion clears request, copies new to current
// - Switching disabled holds request at zero
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
module occ_clock_ctrl
  import occ_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cfg_init_source,
  input wire logic cfg_switch_enable,
  input wire logic [1:0] switch_monitor_config,
  input wire logic unlock_ok,
  input wire logic pll_lock_pin,
  input wire logic fail_detect_pin,
  input wire logic osc_ready_pin,
  input wire logic new_clk_tick,
  input wire logic interrupt_event,
  input wire logic cy_tick,
  input wire logic pps_write_req,
  output logic pps_write_en,
  output logic core_tick,
  output occ_src_e current_source_sel,
  output occ_osc_s osc_out,
  output occ_div_s div_out
);
  // ==========================================================
  // Pin synchronisers
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {pll_lock_pin, fail_detect_pin, osc_ready_pin};
      s2_q <= s1_q;
    end
  end
  logic pll_lock;
  logic fail_det;
  logic osc_ready;
  assign pll_lock = s2_q[2];
  assign fail_det = s2_q[1];
  assign osc_ready = s2_q[0];
  // ==========================================================
  // Bus decode
  logic wr;
  logic rd_sel_ctrl;
  logic hit_ctrl;
  logic hit_div;
  logic hit_fbd;
  logic hit_tune;
  assign hit_ctrl = paddr == `OCC_OFF_OSC_CTRL;
  assign hit_div = paddr == `OCC_OFF_CLK_DIV;
  assign hit_fbd = paddr == `OCC_OFF_PLL_FBD;
  assign hit_tune = paddr == `OCC_OFF_RC_TUNE;
  assign wr = psel && penable && pwrite;
  assign rd_sel_ctrl = hit_ctrl;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   !(hit_ctrl || hit_div || hit_fbd || hit_tune);
  // Control writes need unlock_ok held high by the system
  logic ctrl_wr;
  assign ctrl_wr = wr && hit_ctrl && unlock_ok;
  // ==========================================================
  // Oscillator control state
  occ_src_e cur_q;
  occ_src_e new_q;
  logic freeze_q;
  logic guard_q;
  logic fail_q;
  logic sec_en_q;
  logic req_q;
  logic init_q;
  logic seq_busy;
  logic seq_done;
  logic seq_redundant;
  logic freeze_active;
  logic sw_allowed;
  assign freeze_active = freeze_q &&
    switch_monitor_config == `OCC_MON_SWITCH_ONLY;
  assign sw_allowed = cfg_switch_enable && !freeze_active;
  // Configuration catch one cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_q <= OCC_SRC_RC;
    end else if (init_q) begin
      new_q <= occ_src_e'(cfg_init_source);
    end else if (ctrl_wr) begin
      new_q <= occ_src_e'(pwdata[`OCC_NEW_LSB +: 3]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= OCC_SRC_RC;
    end else if (init_q) begin
      cur_q <= occ_src_e'(cfg_init_source);
    end else if (seq_done) begin
      cur_q <= new_q;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
    end else if (!cfg_switch_enable) begin
      req_q <= 1'b0;
    end else if (seq_done || seq_redundant) begin
      req_q <= 1'b0;
    end else if (ctrl_wr && pwdata[`OCC_REQ_BIT] && sw_allowed) begin
      req_q <= 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_q <= 1'b0;
      guard_q <= 1'b0;
      sec_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      freeze_q <= pwdata[`OCC_FREEZE_BIT];
      guard_q <= pwdata[`OCC_GUARD_BIT];
      sec_en_q <= pwdata[`OCC_SEC_EN_BIT];
    end
  end
  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 1'b0;
    end else if (fail_det) begin
      fail_q <= 1'b1;
    end else if (ctrl_wr && !pwdata[`OCC_FAIL_BIT]) begin
      fail_q <= 1'b0;
    end
  end
  assign pps_write_en = pps_write_req && !guard_q;
  // ==========================================================
  // Switch sequencer
  logic seq_start;
  assign seq_start = req_q && !seq_busy && sw_allowed;
  occ_switch_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start),
    .target(new_q),
    .current(cur_q),
    .new_clk_tick(new_clk_tick),
    .osc_ready(osc_ready),
    .busy(seq_busy),
    .done(seq_done),
    .redundant(seq_redundant)
  );
  // ==========================================================
  // Divisor registers
  logic recover_q;
  logic [2:0] doze_q;
  logic reduction_enable_q;
  logic [2:0] rc_post_q;
  logic [1:0] post_q;
  logic [4:0] pre_q;
  logic [8:0] mult_q;
  logic [5:0] trim_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recover_q <= 1'b0;
      doze_q <= `OCC_DOZE_RST;
      rc_post_q <= `OCC_RC_POST_RST;
      post_q <= `OCC_POST_RST;
      pre_q <= `OCC_PRE_RST;
    end else if (wr && hit_div) begin
      recover_q <= pwdata[`OCC_RECOVER_BIT];
      doze_q <= pwdata[`OCC_DOZE_LSB +: 3];
      rc_post_q <= pwdata[`OCC_RC_POST_LSB +: 3];
      post_q <= pwdata[`OCC_POST_LSB +: 2];
      pre_q <= pwdata[`OCC_PRE_LSB +: 5];
    end
  end
  // Interrupt wins over a same-cycle software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reduction_enable_q <= 1'b0;
    end else if (recover_q && interrupt_event) begin
      reduction_enable_q <= 1'b0;
    end else if (wr && hit_div) begin
      reduction_enable_q <= pwdata[`OCC_REDUCTION_ENABLE_BIT];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_q <= `OCC_MULT_RST;
      trim_q <= `OCC_TRIM_RST;
    end else begin
      if (wr && hit_fbd) begin
        mult_q <= pwdata[8:0];
      end
      if (wr && hit_tune) begin
        trim_q <= pwdata[5:0];
      end
    end
  end
  occ_doze_ctrl u_doze (
    .pclk(pclk),
    .presetn(presetn),
    .cy_tick(cy_tick),
    .reduction_enable(reduction_enable_q),
    .doze(doze_q),
    .core_tick(core_tick)
  );
  // ==========================================================
  // Read mux, unimplemented bits are zero
  logic [15:0] ctrl_rd;
  logic [15:0] rd16;
  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[`OCC_CUR_LSB +: 3] = cur_q;
    ctrl_rd[`OCC_NEW_LSB +: 3] = new_q;
    ctrl_rd[`OCC_FREEZE_BIT] = freeze_q;
    ctrl_rd[`OCC_GUARD_BIT] = guard_q;
    ctrl_rd[`OCC_PLL_LOCK_BIT] = pll_lock;
    ctrl_rd[`OCC_FAIL_BIT] = fail_q;
    ctrl_rd[`OCC_SEC_EN_BIT] = sec_en_q;
    ctrl_rd[`OCC_REQ_BIT] = req_q;
  end
  always_comb begin
    rd16 = 16'h0000;
    if (rd_sel_ctrl) begin
      rd16 = ctrl_rd;
    end else if (hit_div) begin
      rd16 = {recover_q, doze_q, reduction_enable_q, rc_post_q, post_q, 1'b0, pre_q};
    end else if (hit_fbd) begin
      rd16 = {7'h00, mult_q} & `OCC_FBD_MASK;
    end else if (hit_tune) begin
      rd16 = {10'h000, trim_q} & `OCC_TUNE_MASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd16};
    end
  end
  // ==========================================================
  // Outputs
  assign current_source_sel = cur_q;
  assign osc_out = '{sec_en: sec_en_q, req: req_q, target: new_q};
  assign div_out = '{doze: doze_q, reduction_enable: reduction_enable_q, rc_post: rc_post_q,
                     post: post_q, pre: pre_q, mult: mult_q,
                     trim: trim_q};
  // ==========================================================
  // Checks
  req_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_switch_enable |=> !req_q) else $error("request not held low");
  cur_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done |=> cur_q == $past(new_q) && !req_q) else $error("no copy");
  redundant_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    seq_redundant |=> !req_q) else $error("redundant not cleared");
  recover_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    recover_q && interrupt_event |=> !reduction_enable_q) else $error("doze kept");
  guard_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    guard_q |-> !pps_write_en) else $error("pin select leaked");
  fail_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    fail_det |=> fail_q) else $error("fail flag lost");
  freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    freeze_active && !seq_busy |=> $stable(cur_q)) else $error("froze");
  unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(psel && !penable && !pwrite && hit_ctrl) |->
    prdata[31:16] == 16'h0000 && prdata[15] == 1'b0 &&
    prdata[11] == 1'b0 && prdata[4] == 1'b0 && prdata[2] == 1'b0)
    else $error("reserved bit set");
  cover_switch_c: cover property (@(posedge pclk) seq_done);
  cover_redund_c: cover property (@(posedge pclk) seq_redundant);
  cover_fail_c: cover property (@(posedge pclk) fail_det && ctrl_wr);
endmodule
`default_nettype wire

// ==== verilog/occ_map.svh ====
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by every design file of the clock control block
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
// ==========================================================
// Register byte offsets
`define OCC_OFF_OSC_CTRL 12'h000
`define OCC_OFF_CLK_DIV 12'h004
`define OCC_OFF_PLL_FBD 12'h008
`define OCC_OFF_RC_TUNE 12'h00C
// ==========================================================
// Field positions
`define OCC_CUR_LSB 12
`define OCC_NEW_LSB 8
`define OCC_FREEZE_BIT 7
`define OCC_GUARD_BIT 6
`define OCC_PLL_LOCK_BIT 5
`define OCC_FAIL_BIT 3
`define OCC_SEC_EN_BIT 1
`define OCC_REQ_BIT 0
`define OCC_RECOVER_BIT 15
`define OCC_DOZE_LSB 12
`define OCC_REDUCTION_ENABLE_BIT 11
`define OCC_RC_POST_LSB 8
`define OCC_POST_LSB 6
`define OCC_PRE_LSB 0
// ==========================================================
// Reset values and masks
`define OCC_DOZE_RST 3'h3
`define OCC_POST_RST 2'h1
`define OCC_PRE_RST 5'h00
`define OCC_MULT_RST 9'h030
`define OCC_RC_POST_RST 3'h0
`define OCC_TRIM_RST 6'h00
`define OCC_CLK_DIV_MASK 16'hFFDF
`define OCC_FBD_MASK 16'h01FF
`define OCC_TUNE_MASK 16'h003F
`define OCC_MON_SWITCH_ONLY 2'h1
// ==========================================================
// Timing: settle cycles of the new source before changeover
`define OCC_SETTLE_CYCLES 10
`endif

// ==== verilog/occ_pkg.sv ====
// Types shared by the clock control files
// Assumes occ_map.svh for the numbers
package occ_pkg;
  typedef enum logic [2:0] {
    OCC_SRC_RC, OCC_SRC_RC_PLL, OCC_SRC_PRI, OCC_SRC_PRI_PLL,
    OCC_SRC_SEC, OCC_SRC_SLOW_RC, OCC_SRC_RC_16, OCC_SRC_RC_N
  } occ_src_e;
  typedef struct packed {
    logic [2:0] doze;
    logic reduction_enable;
    logic [2:0] rc_post;
    logic [1:0] post;
    logic [4:0] pre;
    logic [8:0] mult;
    logic [5:0] trim;
  } occ_div_s;
  typedef struct packed {
    logic sec_en;
    logic req;
    occ_src_e target;
  } occ_osc_s;
endpackage

// ==== verilog/occ_switch_seq.sv ====
// Clock switch sequencer: redundant check, ready wait, settle count
// Assumes osc_ready comes synchronised from the oscillator side
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
module occ_switch_seq
  import occ_pkg::*;
#(
  parameter int SETTLE = `OCC_SETTLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire occ_src_e target,
  input wire occ_src_e current,
  input wire logic new_clk_tick,
  input wire logic osc_ready,
  output logic busy,
  output logic done,
  output logic redundant
);
  typedef enum logic [1:0] {IDLE, WAIT_RDY, SETTLE_ST} occ_seq_e;
  occ_seq_e st_q;
  logic [7:0] cnt_q;
  // ==========================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= IDLE;
      cnt_q <= 8'h00;
    end else begin
      unique case (st_q)
        IDLE: begin
          if (start && target != current) begin
            st_q <= WAIT_RDY;
          end
        end
        WAIT_RDY: begin
          cnt_q <= 8'h00;
          if (osc_ready) begin
            st_q <= SETTLE_ST;
          end
        end
        SETTLE_ST: begin
          // Ticks of the new source, not of pclk
          if (new_clk_tick) begin
            if (cnt_q == 8'(SETTLE - 1)) begin
              st_q <= IDLE;
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
        end
      endcase
    end
  end
  assign busy = st_q != IDLE;
  assign redundant = start && st_q == IDLE && target == current;
  assign done = st_q == SETTLE_ST && new_clk_tick &&
                cnt_q == 8'(SETTLE - 1);
  // ==========================================================
  // Checks
  redundant_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    redundant |=> st_q == IDLE) else $error("redundant switch started");
  settle_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == SETTLE_ST && new_clk_tick && cnt_q != 8'(SETTLE - 1) |=>
    st_q == SETTLE_ST) else $error("early changeover");
  cover_done_c: cover property (@(posedge pclk) done);
endmodule
`default_nettype wire

// ==== verilog/occ_doze_ctrl.sv ====
// Doze ratio generator: peripheral-to-core enable pulse
// Assumes a one-cycle instruction clock enable from the system
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
module occ_doze_ctrl
  import occ_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cy_tick,
  input wire logic reduction_enable,
  input wire logic [2:0] doze,
  output logic core_tick
);
  logic [6:0] div_q;
  // ==========================================================
  // Counter runs on instruction ticks only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 7'h00;
    end else if (cy_tick) begin
      div_q <= div_q + 7'h01;
    end
  end
  function automatic logic hit(input logic [6:0] c, input logic [2:0] d);
    logic [6:0] m;
    m = 7'((8'h01 << d) - 8'h01);
    hit = (c & m) == m;
  endfunction
  // Cleared enable forces 1:1
  assign core_tick = cy_tick && (!reduction_enable || hit(div_q, doze));
  one_to_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!reduction_enable && cy_tick) |-> core_tick) else $error("doze not 1:1");
  cover_doze_c: cover property (@(posedge pclk) reduction_enable && core_tick);
endmodule
`default_nettype wire

// ==== verification/test_oscillator_clock_control_regs.sv ====
// Self-checking bench for the clock control register block
// Assumes occ_pkg compiled first and occ_map.svh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.svh"
module test_oscillator_clock_control_regs
  import occ_pkg::*;
;
  // ==========================================================
  // Clock, reset and stimulus signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] cfg_init_source = 3'h2;
  logic cfg_switch_enable = 1'b0;
  logic [1:0] switch_monitor_config = `OCC_MON_SWITCH_ONLY;
  logic unlock_ok = 1'b1;
  logic pll_lock_pin = 1'b0;
  logic fail_detect_pin = 1'b0;
  logic osc_ready_pin = 1'b0;
  logic new_clk_tick = 1'b0;
  logic interrupt_event = 1'b0;
  logic cy_tick = 1'b0;
  logic pps_write_req = 1'b0;
  logic pps_write_en;
  logic core_tick;
  occ_src_e current_source_sel;
  occ_osc_s osc_out;
  occ_div_s div_out;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;

  always #50 pclk = ~pclk;

  occ_clock_ctrl uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_init_source(cfg_init_source),
    .cfg_switch_enable(cfg_switch_enable),
    .switch_monitor_config(switch_monitor_config), .unlock_ok(unlock_ok),
    .pll_lock_pin(pll_lock_pin), .fail_detect_pin(fail_detect_pin),
    .osc_ready_pin(osc_ready_pin), .new_clk_tick(new_clk_tick),
    .interrupt_event(interrupt_event), .cy_tick(cy_tick),
    .pps_write_req(pps_write_req), .pps_write_en(pps_write_en),
    .core_tick(core_tick), .current_source_sel(current_source_sel),
    .osc_out(osc_out), .div_out(div_out)
  );

  // ==========================================================
  // Closing, comparison and bus tasks
  task automatic summarize();
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      new_clk_tick <= 1'b1;
      @(posedge pclk);
      new_clk_tick <= 1'b0;
    end
  endtask

  task automatic pulse_int();
    @(posedge pclk);
    interrupt_event <= 1'b1;
    @(posedge pclk);
    interrupt_event <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Counts core enables over 16 instruction ticks
  task automatic doze_count(input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge pclk);
    cy_tick <= 1'b1;
    repeat (16) begin
      @(negedge pclk);
      if (core_tick === 1'b1) n++;
      @(posedge pclk);
    end
    cy_tick <= 1'b0;
    check(n, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_2200);
    check(current_source_sel, 32'h0000_0002);
    rd_chk(`OCC_OFF_CLK_DIV, 32'h0000_3040);
    rd_chk(`OCC_OFF_PLL_FBD, 32'h0000_0030);
    rd_chk(`OCC_OFF_RC_TUNE, 32'h0000_0000);
    check({div_out.post, div_out.pre, div_out.rc_post}, 32'h0000_0100);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(err, 32'h0000_0001);
    check(rd, 32'h0000_0000);
  endtask

  // Switching off: request stays low while every field is written
  task automatic t_fields();
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'hFFFF_FFFF);
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_27C2);
    check(osc_out.sec_en, 32'h0000_0001);
    check(osc_out.target, 32'h0000_0007);
    apb(1'b1, `OCC_OFF_CLK_DIV, 32'hFFFF_FFFF);
    rd_chk(`OCC_OFF_CLK_DIV, 32'h0000_FFDF);
    check({div_out.post, div_out.pre}, 32'h0000_007F);
    apb(1'b1, `OCC_OFF_PLL_FBD, 32'hFFFF_FFFF);
    rd_chk(`OCC_OFF_PLL_FBD, 32'h0000_01FF);
    check(div_out.mult, 32'h0000_01FF);
    apb(1'b1, `OCC_OFF_RC_TUNE, 32'hFFFF_FFFF);
    rd_chk(`OCC_OFF_RC_TUNE, 32'h0000_003F);
    check(div_out.trim, 32'h0000_003F);
    check(current_source_sel, 32'h0000_0002);
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0200);
    unlock_ok <= 1'b0;
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0002);
    unlock_ok <= 1'b1;
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_2200);
  endtask

  task automatic t_status();
    pll_lock_pin <= 1'b1;
    fail_detect_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    fail_detect_pin <= 1'b0;
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_2228);
    pll_lock_pin <= 1'b0;
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0240);
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_2240);
    pps_write_req <= 1'b1;
    @(negedge pclk);
    check(pps_write_en, 32'h0000_0000);
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0200);
    @(negedge pclk);
    check(pps_write_en, 32'h0000_0001);
    @(posedge pclk);
    pps_write_req <= 1'b0;
  endtask

  // Changeover exactly on the tenth new-source cycle
  task automatic t_switch();
    cfg_switch_enable <= 1'b1;
    osc_ready_pin <= 1'b1;
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    ticks(9);
    repeat (3) @(posedge pclk);
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_2001);
    check(osc_out.req, 32'h0000_0001);
    ticks(1);
    repeat (3) @(posedge pclk);
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_0000);
    check(current_source_sel, 32'h0000_0000);
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_0000);
  endtask

  task automatic t_freeze();
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0280);
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0281);
    ticks(12);
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_0280);
    check(current_source_sel, 32'h0000_0000);
    // Monitor on: the freeze bit no longer blocks a switch
    switch_monitor_config <= 2'h0;
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0281);
    ticks(12);
    rd_chk(`OCC_OFF_OSC_CTRL, 32'h0000_2280);
    switch_monitor_config <= `OCC_MON_SWITCH_ONLY;
    apb(1'b1, `OCC_OFF_OSC_CTRL, 32'h0000_0000);
  endtask

  task automatic t_doze();
    apb(1'b1, `OCC_OFF_CLK_DIV, 32'h0000_2840);
    doze_count(32'h0000_0004);
    pulse_int();
    rd_chk(`OCC_OFF_CLK_DIV, 32'h0000_2840);
    apb(1'b1, `OCC_OFF_CLK_DIV, 32'h0000_A840);
    pulse_int();
    rd_chk(`OCC_OFF_CLK_DIV, 32'h0000_A040);
    check(div_out.reduction_enable, 32'h0000_0000);
    doze_count(32'h0000_0010);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_fields();
    t_status();
    t_switch();
    t_freeze();
    t_doze();
    summarize();
  end

  // Run needs well under a thousand cycles
  initial begin
    #2000000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
